/* File: hw/csf_map.svh */
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

// Register word indices, byte address is four times the index
`define CSF_IDX_CTRL 6'h00
`define CSF_IDX_STATUS 6'h01
`define CSF_IDX_GAIN0 6'h04
`define CSF_IDX_OFFSET0 6'h08
`define CSF_IDX_AUX_GAIN 6'h0C

// Control field positions
`define CSF_CTRL_AUX_SEL 0
`define CSF_CTRL_POWER_DOWN 1
`define CSF_CTRL_MONITOR_SEL 2
`define CSF_CTRL_RCLAMP_POL 3
`define CSF_CTRL_VSAMPLE_POL 4
`define CSF_CTRL_CLAMP_EN 5
`define CSF_CTRL_WIDTH 6

// Status field positions
`define CSF_STAT_OVF 16
`define CSF_STAT_LEVEL 20

// Reset values; polarity 0 means active low, so a pin tied high is idle
`define CSF_CTRL_RESET 6'h20
`define CSF_GAIN_RESET 8'h00
`define CSF_OFFSET_RESET 8'h00
`define CSF_BLACK_RESET 10'h000

// Gain law: factor = (256 + code * step) / 256, about 0 dB to 32 dB
`define CSF_GAIN_UNITY 14'h0100
`define CSF_GAIN_STEP 14'h0027
`define CSF_PIX_MAX 10'h3FF

// Pixel rate ceiling and the sampling clock frequency
`define CSF_MAX_RATE_KSPS 27000
`define CSF_SYS_CLK_KHZ 50000

`endif

/* File: hw/csf_pkg.sv */
package csf_pkg;

   // Control bits that steer the datapath, bit 0 is the source select
   typedef struct packed {
      logic clamp_en;
      logic vsample_pol;
      logic rclamp_pol;
      logic monitor_sel;
      logic power_down;
      logic aux_sel;
   } csf_ctrl_t;

   // One processed pixel with its colour slot
   typedef struct packed {
      logic [1:0] colour;
      logic [9:0] data;
   } csf_pix_t;

   // Serial port frame walker
   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_ADDR = 2'b01,
      SPI_DATA = 2'b10,
      SPI_DONE = 2'b11
   } csf_spi_state_t;

endpackage

/* File: hw/csf_fifo.sv */
`timescale 1ns/1ps
module csf_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data,
   output logic [$clog2(DEPTH+1)-1:0] o_level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   // Pointer wrap relies on a power-of-two depth
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("csf_fifo: DEPTH must be a power of two >= 2");
      end
   end

   logic [WIDTH-1:0] mem_q [DEPTH]; // Flop storage
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic push, pop;

   // Honest flags straight from the count
   assign o_ready = (cnt_q != CW'(DEPTH));
   assign o_valid = (cnt_q != '0);
   assign o_data = mem_q[rd_q];
   assign o_level = cnt_q;
   assign push = i_valid & o_ready;
   assign pop = o_valid & i_ready;

   // Next pointers and count
   always_comb begin
      wr_d = push ? wr_q + AW'(1) : wr_q;
      rd_d = pop ? rd_q + AW'(1) : rd_q;
      cnt_d = cnt_q + CW'(push) - CW'(pop);
   end

   // Register pointers; storage needs no reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
      if (push) begin
         mem_q[wr_q] <= i_data;
      end
   end

   AST_FIFO_BOUND: assert property (@(posedge i_clk) disable iff (!i_rst_n) cnt_q <= CW'(DEPTH))
      else $error("fifo count above depth");
endmodule // csf_fifo

/* File: hw/csf_top.sv */
`timescale 1ns/1ps
`include "csf_map.svh"
// Operation
// - Master reset high returns everything to defaults
// - One pixel per pixel clock, up to 27 MSPS
// - Reset-clamp override strobe, programmable polarity
// - Video-sample override strobe, programmable polarity
// - Black clamp strobe pixels cancel black offset
// - Serial port acts only while enable low
// - Serial clock captures input, separate data out
// - Ten-bit pixel word, LSB on bit 0
// - Eight-bit gain code, 0 to 32 dB
// - Four colour gain and offset pairs
// - Auxiliary source with own clamp and gain
// - Power-down stops the pixel path
// - Bit 9 carries the pixel word MSB
// - Monitor output selects sampler or gain stage
module csf_top #(
   parameter int PIPE_LAT = 3,
   parameter int FIFO_DEPTH = 16,
   parameter int SPI_AW = 8,
   parameter int SPI_DW = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_master_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_pixel_clk,
   input wire logic [9:0] i_adc_sample,
   input wire logic [9:0] i_aux_sample,
   input wire logic i_line_valid_in,
   input wire logic i_black_clamp_strobe,
   input wire logic i_reset_clamp_override,
   input wire logic i_video_sample_override,
   input wire logic i_analog_clamp_switch,
   input wire logic i_serial_ce_n,
   input wire logic i_serial_clk,
   input wire logic i_serial_in,
   output logic o_serial_out,
   output logic [9:0] o_pixel_word,
   output logic [1:0] o_pixel_colour,
   output logic o_pixel_valid,
   input wire logic i_pixel_ready,
   output logic o_reset_clamp_active,
   output logic o_video_sample_active,
   output logic o_aux_clamp_active,
   output logic o_monitor_sel,
   output logic o_power_down,
   output logic o_aux_select
);
   localparam int FW = 12; // Pixel plus colour
   localparam int LW = $clog2(FIFO_DEPTH+1);
   localparam int FL = SPI_AW + SPI_DW;
   // Sampling clock must resolve each pixel clock half period
   localparam int MIN_PIX_CYC = (`CSF_SYS_CLK_KHZ + `CSF_MAX_RATE_KSPS - 1) / `CSF_MAX_RATE_KSPS;

   // Refuse settings the logic cannot serve
   initial begin
      if (PIPE_LAT < 1 || SPI_AW < 7 || SPI_DW < 1 || SPI_DW > 32 || FL > 63 || LW > 5 || MIN_PIX_CYC < 2) begin
         $error("csf_top: unsupported parameter set");
      end
   end

   // Two-stage synchronisers for every sensor pin, the serial port pins and the master reset
   logic [29:0] sync1_q, sync2_q;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         sync1_q <= 30'h0000_00B0; // Enable and overrides idle high
         sync2_q <= 30'h0000_00B0;
      end else begin
         sync1_q <= {i_aux_sample, i_adc_sample, i_serial_in, i_serial_clk, i_serial_ce_n,
                     i_analog_clamp_switch, i_video_sample_override, i_reset_clamp_override,
                     i_black_clamp_strobe, i_line_valid_in, i_pixel_clk, i_master_reset};
         sync2_q <= sync1_q;
      end
   end

   // Synchronised views, read from the second stage only
   logic mrst_s, pclk_s, lv_s, bclamp_s, rco_s, vso_s, analog_clamp_switch_s, ce_n_s, sclk_s, si_s;
   logic [9:0] adc_s, aux_s;
   assign {aux_s, adc_s, si_s, sclk_s, ce_n_s, analog_clamp_switch_s, vso_s, rco_s, bclamp_s, lv_s, pclk_s, mrst_s} = sync2_q;

   // Master reset pin joins the bus reset; bench pulls the pin low when unused
   logic rst_all;
   assign rst_all = !i_rst_n || mrst_s;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (rst_all);

   // Read mux shared by bus and serial port
   function automatic logic [31:0] read_reg(input logic [5:0] idx, input csf_pkg::csf_ctrl_t ctl,
                                            input logic [7:0] gn [4], input logic [7:0] of [4],
                                            input logic [7:0] ag, input logic [9:0] blk,
                                            input logic ovf, input logic [LW-1:0] lvl);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (idx == `CSF_IDX_CTRL) r[`CSF_CTRL_WIDTH-1:0] = ctl;
      else if (idx == `CSF_IDX_STATUS) begin
         r[9:0] = blk;
         r[`CSF_STAT_OVF] = ovf;
         r[`CSF_STAT_LEVEL +: LW] = lvl;
      end
      else if (idx[5:2] == `CSF_IDX_GAIN0 >> 2) r[7:0] = gn[idx[1:0]];
      else if (idx[5:2] == `CSF_IDX_OFFSET0 >> 2) r[7:0] = of[idx[1:0]];
      else if (idx == `CSF_IDX_AUX_GAIN) r[7:0] = ag;
      return r;
   endfunction

   function automatic logic is_mapped(input logic [5:0] idx);
      return idx <= `CSF_IDX_STATUS || (idx >= `CSF_IDX_GAIN0 && idx <= `CSF_IDX_AUX_GAIN);
   endfunction

   // Gain stage and offset with saturation, shared by both sources
   function automatic logic [9:0] apply_gain(input logic [9:0] lvl, input logic [7:0] code,
                                             input logic [7:0] off);
      logic [13:0] mult;
      logic [23:0] prod;
      logic [16:0] sum;
      mult = `CSF_GAIN_UNITY + 14'(code) * `CSF_GAIN_STEP;
      prod = 24'(lvl) * 24'(mult);
      sum = 17'(prod[23:8]) + 17'(off);
      return (sum > 17'(`CSF_PIX_MAX)) ? `CSF_PIX_MAX : sum[9:0];
   endfunction

   // ---------------- Register file ----------------
   csf_pkg::csf_ctrl_t ctrl_q, ctrl_d;
   logic [7:0] gain_q [4], gain_d [4]; // One per colour slot
   logic [7:0] offs_q [4], offs_d [4];
   logic [7:0] aux_gain_q, aux_gain_d;
   logic ovf_q, ovf_d; // Sticky FIFO overflow
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic [9:0] black_q; // Running black level
   logic [LW-1:0] fifo_level;
   logic spi_wr; // Serial write strobe
   logic [5:0] spi_idx;
   logic [SPI_DW-1:0] spi_wdata;
   logic fifo_drop; // Pixel lost to a full FIFO

   logic acc_first, apb_wr, wr_en;
   logic [5:0] wr_idx, apb_idx;
   logic [31:0] wr_data;
   assign apb_idx = i_paddr[7:2];
   assign acc_first = i_psel && i_penable && !pready_q;
   assign apb_wr = i_psel && i_penable && pready_q && i_pwrite && is_mapped(apb_idx);

   // Next register values; bus write wins a same-cycle serial write
   always_comb begin
      ctrl_d = ctrl_q;
      gain_d = gain_q;
      offs_d = offs_q;
      aux_gain_d = aux_gain_q;
      wr_en = apb_wr || spi_wr;
      wr_idx = apb_wr ? apb_idx : spi_idx;
      wr_data = apb_wr ? i_pwdata : 32'(spi_wdata);
      ovf_d = ovf_q;
      if (wr_en) begin
         if (wr_idx == `CSF_IDX_CTRL) ctrl_d = csf_pkg::csf_ctrl_t'(wr_data[`CSF_CTRL_WIDTH-1:0]);
         else if (wr_idx == `CSF_IDX_STATUS && wr_data[`CSF_STAT_OVF]) ovf_d = 1'b0; // Write one clears
         else if (wr_idx[5:2] == `CSF_IDX_GAIN0 >> 2) gain_d[wr_idx[1:0]] = wr_data[7:0];
         else if (wr_idx[5:2] == `CSF_IDX_OFFSET0 >> 2) offs_d[wr_idx[1:0]] = wr_data[7:0];
         else if (wr_idx == `CSF_IDX_AUX_GAIN) aux_gain_d = wr_data[7:0];
      end
      if (fifo_drop) ovf_d = 1'b1; // Set beats clear
      // Access phase gets one wait state, answer registered
      pready_d = acc_first;
      pslverr_d = acc_first && !is_mapped(apb_idx);
      prdata_d = 32'h0000_0000;
      if (acc_first && !i_pwrite) begin
         prdata_d = read_reg(apb_idx, ctrl_q, gain_q, offs_q, aux_gain_q, black_q, ovf_q, fifo_level);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         ctrl_q <= csf_pkg::csf_ctrl_t'(`CSF_CTRL_RESET);
         gain_q <= '{default: `CSF_GAIN_RESET};
         offs_q <= '{default: `CSF_OFFSET_RESET};
         aux_gain_q <= `CSF_GAIN_RESET;
         ovf_q <= 1'b0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         gain_q <= gain_d;
         offs_q <= offs_d;
         aux_gain_q <= aux_gain_d;
         ovf_q <= ovf_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_prdata = prdata_q;
   assign o_monitor_sel = ctrl_q.monitor_sel;
   assign o_power_down = ctrl_q.power_down;
   assign o_aux_select = ctrl_q.aux_sel;

   sequence s_access_wait;
      i_psel && i_penable && !pready_q;
   endsequence
   AST_APB_ONE_WAIT: assert property (s_access_wait |=> pready_q)
      else $error("bus answer not given one cycle into access");
   AST_RESET_DEFAULTS: assert property (@(posedge i_sys_clk) disable iff (1'b0)
      rst_all |=> ctrl_q == csf_pkg::csf_ctrl_t'(`CSF_CTRL_RESET) && !ovf_q && !o_pixel_valid)
      else $error("state not at defaults after reset");
   AST_MONITOR_FOLLOWS: assert property (apb_wr && apb_idx == `CSF_IDX_CTRL
      |=> o_monitor_sel == $past(i_pwdata[`CSF_CTRL_MONITOR_SEL]))
      else $error("monitor select did not follow write");

   // ---------------- Override strobes ----------------
   logic rca_q, rca_d, vsa_q, vsa_d, aca_q, aca_d;
   always_comb begin
      rca_d = ctrl_q.rclamp_pol ? rco_s : !rco_s;
      vsa_d = ctrl_q.vsample_pol ? vso_s : !vso_s;
      aca_d = analog_clamp_switch_s && ctrl_q.aux_sel;
   end
   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         rca_q <= 1'b0;
         vsa_q <= 1'b0;
         aca_q <= 1'b0;
      end else begin
         rca_q <= rca_d;
         vsa_q <= vsa_d;
         aca_q <= aca_d;
      end
   end
   assign o_reset_clamp_active = rca_q;
   assign o_video_sample_active = vsa_q;
   assign o_aux_clamp_active = aca_q;

   AST_RCLAMP_POL: assert property (##1 o_reset_clamp_active == ($past(rco_s) ~^ $past(ctrl_q.rclamp_pol)))
      else $error("reset clamp override polarity wrong");
   AST_VSAMPLE_POL: assert property (##1 o_video_sample_active == ($past(vso_s) ~^ $past(ctrl_q.vsample_pol)))
      else $error("video sample override polarity wrong");

   // ---------------- Serial port ----------------
   csf_pkg::csf_spi_state_t spi_st_q, spi_st_d;
   logic [5:0] spi_cnt_q, spi_cnt_d;
   logic [FL-1:0] shin_q, shin_d;
   logic [SPI_DW-1:0] shout_q, shout_d;
   logic so_q, so_d, sclk_prev_q, spi_wr_d, spi_wr_q, spi_rd_q, spi_rd_d;
   logic sclk_rise, sclk_fall;
   logic [31:0] spi_rword;
   assign sclk_rise = sclk_s && !sclk_prev_q;
   assign sclk_fall = !sclk_s && sclk_prev_q;
   assign spi_idx = shin_q[SPI_DW +: 6];
   assign spi_wdata = shin_q[SPI_DW-1:0];
   assign spi_wr = spi_wr_q;
   // Index from the bits already held plus the one arriving, so no loop through shin_d
   assign spi_rword = read_reg({shin_q[4:0], si_s}, ctrl_q, gain_q, offs_q, aux_gain_q, black_q, ovf_q, fifo_level);

   // Frame walker: address bits MSB first, top address bit flags a read
   always_comb begin
      spi_st_d = spi_st_q;
      spi_cnt_d = spi_cnt_q;
      shin_d = shin_q;
      shout_d = shout_q;
      so_d = so_q;
      spi_rd_d = spi_rd_q;
      spi_wr_d = 1'b0;
      case (spi_st_q)
         csf_pkg::SPI_IDLE: begin
            spi_cnt_d = 6'h00;
            if (!ce_n_s) spi_st_d = csf_pkg::SPI_ADDR;
         end
         csf_pkg::SPI_ADDR: begin
            if (sclk_rise) begin
               shin_d = {shin_q[FL-2:0], si_s};
               spi_cnt_d = spi_cnt_q + 6'h01;
               if (spi_cnt_d == 6'(SPI_AW)) begin
                  spi_st_d = csf_pkg::SPI_DATA;
                  spi_rd_d = shin_d[SPI_AW-1];
                  shout_d = spi_rword[SPI_DW-1:0];
               end
            end
         end
         csf_pkg::SPI_DATA: begin
            if (sclk_fall && spi_rd_q) begin
               so_d = shout_q[SPI_DW-1];
               shout_d = {shout_q[SPI_DW-2:0], 1'b0};
            end
            if (sclk_rise) begin
               shin_d = {shin_q[FL-2:0], si_s};
               spi_cnt_d = spi_cnt_q + 6'h01;
               if (spi_cnt_d == 6'(FL)) begin
                  spi_st_d = csf_pkg::SPI_DONE;
                  spi_wr_d = !spi_rd_q && is_mapped(shin_d[SPI_DW +: 6]);
               end
            end
         end
         csf_pkg::SPI_DONE: begin
            spi_cnt_d = spi_cnt_q; // Extra clocks ignored until enable rises
         end
         default: spi_st_d = csf_pkg::SPI_IDLE;
      endcase
      if (ce_n_s) begin
         spi_st_d = csf_pkg::SPI_IDLE;
         spi_cnt_d = 6'h00;
         so_d = 1'b0;
         spi_wr_d = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         spi_st_q <= csf_pkg::SPI_IDLE;
         spi_cnt_q <= 6'h00;
         shin_q <= '0;
         shout_q <= '0;
         so_q <= 1'b0;
         spi_rd_q <= 1'b0;
         spi_wr_q <= 1'b0;
         sclk_prev_q <= 1'b0;
      end else begin
         spi_st_q <= spi_st_d;
         spi_cnt_q <= spi_cnt_d;
         shin_q <= shin_d;
         shout_q <= shout_d;
         so_q <= so_d;
         spi_rd_q <= spi_rd_d;
         spi_wr_q <= spi_wr_d;
         sclk_prev_q <= sclk_s;
      end
   end
   assign o_serial_out = so_q;

   AST_SPI_IGNORED: assert property (ce_n_s |=> spi_cnt_q == 6'h00 && !o_serial_out && !spi_wr)
      else $error("serial port active while disabled");

   // ---------------- Pixel path ----------------
   logic pclk_prev_q, lv_prev_q, pix_par_q, line_par_q, pix_edge;
   logic pclk_prev_d, lv_prev_d, pix_par_d, line_par_d;
   logic [9:0] black_d, sample, level;
   csf_pkg::csf_pix_t pipe_q [PIPE_LAT], pipe_d [PIPE_LAT];
   logic [PIPE_LAT-1:0] pvld_q, pvld_d;
   logic [1:0] colour;
   logic fifo_in_ready, fifo_out_valid, out_take;
   csf_pkg::csf_pix_t fifo_out;
   logic out_vld_q, out_vld_d;
   csf_pkg::csf_pix_t out_q, out_d;

   assign pix_edge = pclk_s && !pclk_prev_q;
   assign colour = {line_par_q, pix_par_q};
   assign sample = ctrl_q.aux_sel ? aux_s : adc_s;
   // Black offset only applies to the sensor path; aux has its own clamp
   assign level = ctrl_q.aux_sel ? aux_s : ((adc_s > black_q) ? adc_s - black_q : 10'h000);
   assign fifo_drop = pix_edge && pvld_q[PIPE_LAT-1] && !fifo_in_ready;

   // One sample per pixel clock edge, shifted down a fixed-length pipe
   always_comb begin
      pclk_prev_d = pclk_s;
      lv_prev_d = lv_prev_q;
      pix_par_d = pix_par_q;
      line_par_d = line_par_q;
      black_d = black_q;
      pipe_d = pipe_q;
      pvld_d = pvld_q;
      if (pix_edge) begin
         lv_prev_d = lv_s;
         if (lv_prev_q && !lv_s) line_par_d = !line_par_q;
         pix_par_d = lv_s ? !pix_par_q : 1'b0;
         if (bclamp_s && ctrl_q.clamp_en && !ctrl_q.aux_sel) begin
            // Signed error so a darker pixel pulls the level down
            black_d = black_q + 10'($signed(11'(sample) - 11'(black_q)) >>> 3);
         end
         for (int i = PIPE_LAT - 1; i > 0; i--) begin
            pipe_d[i] = pipe_q[i-1];
            pvld_d[i] = pvld_q[i-1];
         end
         pvld_d[0] = lv_s && !ctrl_q.power_down;
         pipe_d[0].colour = colour;
         pipe_d[0].data = ctrl_q.aux_sel ? apply_gain(level, aux_gain_q, 8'h00)
                                         : apply_gain(level, gain_q[colour], offs_q[colour]);
      end
      if (ctrl_q.power_down) pvld_d = '0;
   end

   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         pclk_prev_q <= 1'b0;
         lv_prev_q <= 1'b0;
         pix_par_q <= 1'b0;
         line_par_q <= 1'b0;
         black_q <= `CSF_BLACK_RESET;
         pipe_q <= '{default: '0};
         pvld_q <= '0;
      end else begin
         pclk_prev_q <= pclk_prev_d;
         lv_prev_q <= lv_prev_d;
         pix_par_q <= pix_par_d;
         line_par_q <= line_par_d;
         black_q <= black_d;
         pipe_q <= pipe_d;
         pvld_q <= pvld_d;
      end
   end

   csf_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk(i_sys_clk),
      .i_rst_n(!rst_all),
      .i_valid(pix_edge && pvld_q[PIPE_LAT-1]),
      .o_ready(fifo_in_ready),
      .i_data(pipe_q[PIPE_LAT-1]),
      .o_valid(fifo_out_valid),
      .i_ready(out_take),
      .o_data(fifo_out),
      .o_level(fifo_level)
   );

   // Output register so the pixel port comes from flops and can stall
   assign out_take = fifo_out_valid && (!out_vld_q || i_pixel_ready);
   always_comb begin
      out_vld_d = out_vld_q;
      out_d = out_q;
      if (out_take) begin
         out_vld_d = 1'b1;
         out_d = fifo_out;
      end else if (i_pixel_ready) begin
         out_vld_d = 1'b0;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (rst_all) begin
         out_vld_q <= 1'b0;
         out_q <= '0;
      end else begin
         out_vld_q <= out_vld_d;
         out_q <= out_d;
      end
   end
   assign o_pixel_valid = out_vld_q;
   assign o_pixel_word = out_q.data;
   assign o_pixel_colour = out_q.colour;

   sequence s_no_clamp_edge;
      !(pix_edge && bclamp_s);
   endsequence
   AST_BLACK_ONLY_ON_CLAMP: assert property (s_no_clamp_edge |=> $stable(black_q))
      else $error("black level moved without clamp strobe");
   AST_PUSH_ON_EDGE: assert property (pvld_q[0] && !$past(pvld_q[0]) |-> $past(pix_edge) && $past(lv_s))
      else $error("pixel entered pipe without a pixel clock edge in line");
   AST_HOLD_STALLED: assert property (o_pixel_valid && !i_pixel_ready |=> o_pixel_valid && $stable(o_pixel_word))
      else $error("pixel word changed while stalled");
   AST_POWER_DOWN_EMPTY: assert property (ctrl_q.power_down [*2] |-> pvld_q == '0)
      else $error("pixel pipe active while powered down");
endmodule // csf_top

/* File: testbench/csf_pix_gen_model.sv */
`timescale 1ns/1ps
// Sensor timing generator: free pixel clock and line framing
module csf_pix_gen_model (
   input wire logic i_clk,
   output logic o_pclk,
   output logic o_lv,
   output logic o_blk,
   output logic [9:0] o_smp
);
   logic [9:0] q[$]; // Samples queued by the bench
   initial begin
      o_pclk = 1'b0;
      o_lv = 1'b0;
      o_blk = 1'b0;
      o_smp = 10'h000;
   end
   // Pixel clock runs free, 8 system clocks a period
   always begin
      repeat (4) @(posedge i_clk);
      o_pclk <= ~o_pclk;
   end
   // Data change on falling edges, stable at each rise
   task automatic line(input int n);
      @(negedge o_pclk);
      o_lv <= 1'b1;
      for (int i = 0; i < n; i++) begin
         o_smp <= q.pop_front();
         @(negedge o_pclk);
      end
      o_lv <= 1'b0;
      o_smp <= ~o_smp; // Blanking shows no stale sample
      repeat (3) @(negedge o_pclk);
   endtask
   // Optically black pixels with the clamp strobe high
   task automatic clamp(input int n);
      @(negedge o_pclk);
      o_blk <= 1'b1;
      for (int i = 0; i < n; i++) begin
         o_smp <= q.pop_front();
         @(negedge o_pclk);
      end
      o_blk <= 1'b0;
   endtask
endmodule // csf_pix_gen_model

/* File: testbench/tb_camera_signal_frontend_control.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("Error %0t %h %h", $time, a, b); end end
module tb_camera_signal_frontend_control;
   logic clk = 0, rst_n = 0, mr = 0, psel = 0, pen = 0, pwr = 0, rcov = 1, vsov = 1, acs = 0;
   logic ce_n = 1, sck = 0, si = 0, rdy = 0, rdy_en = 0, mon = 1, e;
   logic [7:0] pa = 0, r8;
   logic [7:0] g[4], o[4]; // Per-colour gain and offset
   logic [31:0] pd = 0, r;
   logic [9:0] s, b = 10'h000;
   logic [1:0] k;
   logic [11:0] x;
   logic [11:0] exp_q[$]; // Expected colour and word
   wire pclk, lv, blk, so, pv, prdy, perr, rca, vsa, aca, msel, pdn, axs;
   wire [9:0] smp, pw;
   wire [1:0] pc;
   wire [31:0] prd;
   int bad_count = 0, num_checks = 0;
   csf_pix_gen_model p (.i_clk(clk), .o_pclk(pclk), .o_lv(lv), .o_blk(blk), .o_smp(smp));
   csf_top #(.FIFO_DEPTH(16)) DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_master_reset(mr), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pd), .o_prdata(prd), .o_pready(prdy),
      .o_pslverr(perr), .i_pixel_clk(pclk), .i_adc_sample(smp), .i_aux_sample(smp), .i_line_valid_in(lv),
      .i_black_clamp_strobe(blk), .i_reset_clamp_override(rcov), .i_video_sample_override(vsov),
      .i_analog_clamp_switch(acs), .i_serial_ce_n(ce_n), .i_serial_clk(sck), .i_serial_in(si),
      .o_serial_out(so), .o_pixel_word(pw), .o_pixel_colour(pc), .o_pixel_valid(pv), .i_pixel_ready(rdy),
      .o_reset_clamp_active(rca), .o_video_sample_active(vsa), .o_aux_clamp_active(aca),
      .o_monitor_sel(msel), .o_power_down(pdn), .o_aux_select(axs));
   initial forever #10 clk = ~clk;
   // APB cycle, result left in r and e
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Serial frame, MSB first; slow clock keeps sync margin
   task automatic ser(input logic [15:0] f, input logic ce);
      ce_n <= ce;
      repeat (8) @(posedge clk);
      for (int i = 15; i >= 0; i--) begin
         si <= f[i];
         repeat (8) @(posedge clk);
         if (i < 8) r8[i] = so;
         sck <= 1'b1;
         repeat (8) @(posedge clk);
         sck <= 1'b0;
      end
      repeat (8) @(posedge clk);
      ce_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   // Gain law with saturation at full scale
   function automatic logic [9:0] f_exp(input logic [9:0] a, input logic [7:0] gc, input logic [7:0] of);
      int v;
      v = ((a * (256 + gc * 39)) >> 8) + of;
      return (v > 1023) ? 10'h3FF : v[9:0];
   endfunction
   // Black level moves an eighth of the error, rounding down
   function automatic logic [9:0] f_blk(input logic [9:0] bl, input logic [9:0] sv);
      int d;
      d = int'(sv) - int'(bl);
      return 10'(int'(bl) + (d >>> 3));
   endfunction
   task automatic report_and_stop;
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #1_000_000;
      bad_count++;
      report_and_stop();
   end
   // Output monitor; sink stalls at random
   always @(posedge clk) begin
      if (pv === 1'b1 && rdy === 1'b1 && mon) begin
         `CHK(exp_q.size() > 0, 1'b1)
         x = exp_q.size() ? exp_q.pop_front() : 12'h000;
         `CHK({pc, pw}, x)
      end
      rdy <= rdy_en ? ($urandom % 4 != 0) : 1'b0;
   end
   initial begin
      void'($urandom(48));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, 8'h00, 0);
      `CHK(r, 32'h0000_0020)
      apb(0, 8'hFC, 32'h0000_FFFF);
      `CHK({r, e}, {32'h0000_0000, 1'b1})
      acs <= 1'b1;
      apb(1, 8'h00, 32'h0000_0007);
      apb(0, 8'h00, 0);
      `CHK({aca, pdn, msel, axs}, 4'hF)
      mr <= 1'b1;
      repeat (4) @(posedge clk);
      mr <= 1'b0;
      repeat (4) @(posedge clk);
      apb(0, 8'h00, 0);
      `CHK({r, aca, pdn, msel, axs}, {32'h0000_0020, 4'h0})
      rcov <= 1'b0;
      vsov <= 1'b0;
      apb(0, 8'h00, 0);
      `CHK({rca, vsa}, 2'b11)
      apb(1, 8'h00, 32'h0000_0038);
      apb(0, 8'h00, 0);
      `CHK({rca, vsa}, 2'b00)
      apb(1, 8'h00, 32'h0000_0020);
      for (int i = 0; i < 4; i++) begin
         g[i] = (i == 1) ? 8'hFF : 8'($urandom);
         o[i] = 8'($urandom);
         apb(1, 8'h10 + 8'(4 * i), {24'h0, g[i]});
         apb(1, 8'h20 + 8'(4 * i), {24'h0, o[i]});
      end
      apb(0, 8'h10, 0);
      `CHK(r, {24'h0, g[0]})
      rdy_en = 1'b1;
      for (int ln = 0; ln < 4; ln++) begin
         for (int i = 0; i < 5 + ln; i++) begin
            s = (ln == 0 && i < 2) ? (i ? 10'h3FF : 10'h000) : 10'($urandom);
            k = {ln[0], i[0]};
            p.q.push_back(s);
            exp_q.push_back({k, f_exp(s, g[k], o[k])});
         end
         p.line(5 + ln);
      end
      for (int t = 0; t < 400 && exp_q.size() > 0; t++) @(posedge clk);
      `CHK(exp_q.size(), 0)
      for (int i = 0; i < 4; i++) begin
         s = (i < 2) ? (i ? 10'h000 : 10'h3FF) : 10'($urandom);
         p.q.push_back(s);
         b = f_blk(b, s);
      end
      p.clamp(4);
      apb(0, 8'h04, 0);
      `CHK(r[9:0], b)
      ser(16'h0CA5, 1'b0);
      apb(0, 8'h30, 0);
      `CHK(r, 32'h0000_00A5)
      ser(16'h0C5A, 1'b1);
      ser(16'h8C00, 1'b0);
      `CHK({r8, so}, {8'hA5, 1'b0})
      apb(1, 8'h00, 32'h0000_0021);
      for (int i = 0; i < 4; i++) begin
         s = 10'($urandom);
         p.q.push_back(s);
         exp_q.push_back({1'b0, i[0], f_exp(s, 8'hA5, 8'h00)});
      end
      p.line(4);
      for (int t = 0; t < 400 && exp_q.size() > 0; t++) @(posedge clk);
      `CHK(exp_q.size(), 0)
      apb(1, 8'h00, 32'h0000_0022);
      for (int i = 0; i < 4; i++) p.q.push_back(10'($urandom));
      p.line(4);
      apb(1, 8'h00, 32'h0000_0020);
      rdy_en = 1'b0;
      for (int i = 0; i < 20; i++) p.q.push_back(10'($urandom));
      p.line(20);
      apb(0, 8'h04, 0);
      `CHK(r[16], 1'b1)
      apb(1, 8'h04, 32'h0001_0000);
      mon = 1'b0;
      rdy_en = 1'b1;
      repeat (100) @(posedge clk);
      apb(0, 8'h04, 0);
      `CHK({r[16], r[24:20]}, 6'h00)
      report_and_stop();
   end
endmodule // tb_camera_signal_frontend_control
